// ===== pkg/sysrst_map.svh
// Offsets, field positions, reset values and timing figures of the reset sequencer.
// Assumes a 25 MHz host clock and a 32-bit APB register port.
`ifndef SYSRST_MAP_SVH
`define SYSRST_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYSRST_CLK_MHZ        25
`define SYSRST_HOLD_NS        1000
`define SYSRST_INIT_NS        400
`define SYSRST_BRIDGE_NS      1000
`define SYSRST_CFG_POST_CLK   1
`define SYSRST_RATIO_POST_CLK 2
`define SYSRST_REQ0_POST_CLK  2
`define SYSRST_REFRESH_PER_BANK 8

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SYSRST_OFS_DRIVE   8'h00
`define SYSRST_OFS_CAPTURE 8'h04
`define SYSRST_OFS_CONTROL 8'h08
`define SYSRST_OFS_STATUS  8'h0C

// ----------------------------------------
// Boot configuration fields
// ----------------------------------------
`define SYSRST_CFG_PARITY_EN  0
`define SYSRST_CFG_ADDR_ERR_EN 1
`define SYSRST_CFG_BUS_ERR_EN 2
`define SYSRST_CFG_FATAL_EN   3
`define SYSRST_CFG_REDUNDANCY 4
`define SYSRST_CFG_VECTOR_4G  5
`define SYSRST_CFG_QUEUE_DEEP 6
`define SYSRST_CFG_CLUSTER_LO 7
`define SYSRST_CFG_ARB_LO     9
`define SYSRST_DRIVE_RST      13'h0040

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define SYSRST_CTL_HARD       0
`define SYSRST_CTL_BIST       1
`define SYSRST_CTL_SOFT       2
`define SYSRST_CTL_BRIDGE_LO  3
`define SYSRST_CTL_REPHASE    5
`define SYSRST_STS_FATAL      0
`define SYSRST_STS_REFRESH    1
`define SYSRST_STS_STATE_LO   2
`define SYSRST_STS_FETCH      4

`endif

// ===== pkg/sysrst_pkg.sv
// Types shared by the reset sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package sysrst_pkg;

	// Sequencer phases
	typedef enum logic [1:0]
	{
		SYSRST_ST_HOLD  = 2'b00,
		SYSRST_ST_DRIVE = 2'b01,
		SYSRST_ST_RUN   = 2'b10
	} sysrst_state_t;

	// Cause of the reset being sequenced
	typedef enum logic [1:0]
	{
		SYSRST_K_POWER = 2'b00,
		SYSRST_K_HARD  = 2'b01,
		SYSRST_K_FATAL = 2'b10
	} sysrst_kind_t;

endpackage

// ===== src/sysrst_seq.sv
// Reset and boot configuration sequencer with an APB register port.
// Assumes reset_n is the power-good level, all inputs synchronous to clk.
`timescale 1ns/1ps
`include "sysrst_map.svh"

module sysrst_seq
	import sysrst_pkg::*;
#(
	parameter int NB_BRIDGES = 2,
	parameter int NB_BANKS   = 4,
	parameter int CFG_W      = 13,
	parameter int HOLD_CYC   = (`SYSRST_HOLD_NS * `SYSRST_CLK_MHZ + 999) / 1000,
	parameter int INIT_CYC   = (`SYSRST_INIT_NS * `SYSRST_CLK_MHZ + 999) / 1000,
	parameter int BRIDGE_CYC = (`SYSRST_BRIDGE_NS * `SYSRST_CLK_MHZ + 999) / 1000
)
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             ce,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [CFG_W-1:0] cfg_in,
	output logic      [CFG_W-1:0] cfg_out,
	output logic                  cfg_oe,
	input  wire logic             bus_fatal_n,
	output logic                  symmetric_request0_n,
	output logic                  symmetric_request0_oe,
	output logic                  cpu_reset_n,
	output logic                  cpu_init_n,
	output logic                  ratio_select_hold_n,
	output logic                  memory_subsystem_clear_n,
	output logic                  refresh_strobe,
	output logic      [1:0]       refresh_bank,
	output logic                  power_ok_buffered_out,
	output logic                  boot_fetch_en,
	output logic [NB_BRIDGES-1:0] bridge_reset_n,
	input  wire logic             pci_fb_a,
	input  wire logic             pci_fb_b,
	output wire logic             pci_clock_a,
	output wire logic             pci_clock_b
);

	// ----------------------------------------
	// Local constants and state
	// ----------------------------------------
	localparam logic [15:0] HOLD_LAST   = 16'(HOLD_CYC - 1);
	localparam logic [15:0] INIT_LAST   = 16'(INIT_CYC - 1);
	localparam logic [15:0] BRIDGE_LAST = 16'(BRIDGE_CYC - 1);
	localparam logic [1:0]  CFG_LAST    = 2'(`SYSRST_CFG_POST_CLK - 1);
	localparam logic [1:0]  RATIO_LAST  = 2'(`SYSRST_RATIO_POST_CLK - 1);
	localparam logic [1:0]  REQ0_LAST   = 2'(`SYSRST_REQ0_POST_CLK - 1);
	localparam logic [7:0]  REFRESH_ALL = 8'(`SYSRST_REFRESH_PER_BANK * NB_BANKS);

	sysrst_state_t          st_r;
	sysrst_kind_t           kind_r;
	logic [15:0]            cnt_r;
	logic [1:0]             post_r;
	logic [CFG_W-1:0]       drive_r;
	logic [CFG_W-1:0]       capture_r;
	logic                   hard_go_r;
	logic                   soft_go_r;
	logic [NB_BRIDGES-1:0]  br_go_r;
	logic                   bist_r;
	logic                   rephase_en_r;
	logic                   fatal_seen_r;
	logic [15:0]            init_cnt_r;
	logic [7:0]             refresh_left_r;
	logic [NB_BRIDGES-1:0]  pci_clock_r;
	logic [NB_BRIDGES-1:0]  pci_fb;
	logic                   acc_first;
	logic                   done;
	logic                   hard_take;
	logic                   fatal_take;
	logic                   full_hold;

	assign pci_fb     = {pci_fb_b, pci_fb_a};
	assign pci_clock_a = pci_clock_r[0];
	assign pci_clock_b = pci_clock_r[1];

	// APB phases: first access cycle reads, the pready edge commits a write
	assign acc_first = psel && penable && !pready;
	assign done      = psel && penable && pready && ce;

	// A hard request wins over a simultaneous bus fatal event
	assign hard_take  = (st_r == SYSRST_ST_RUN) && hard_go_r;
	assign fatal_take = (st_r == SYSRST_ST_RUN) && !hard_go_r && !bus_fatal_n
		&& capture_r[`SYSRST_CFG_FATAL_EN];
	assign full_hold  = (st_r == SYSRST_ST_HOLD) && (kind_r != SYSRST_K_FATAL);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// One wait state; unmapped offsets answer with pslverr and zero data
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready  <= acc_first;
			pslverr <= 1'b0;
			if (acc_first)
			begin
				prdata <= 32'h0000_0000;
				unique case (paddr)
					`SYSRST_OFS_DRIVE:   prdata <= 32'(drive_r);
					`SYSRST_OFS_CAPTURE: prdata <= 32'(capture_r);
					`SYSRST_OFS_CONTROL: prdata <= 32'({rephase_en_r, 3'b000, bist_r, 1'b0});
					`SYSRST_OFS_STATUS:  prdata <= 32'({boot_fetch_en, st_r,
						(refresh_left_r != 8'h00), fatal_seen_r});
					default:             pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Drive register: only power-good resets it to 0x0040, a hard reset leaves it alone
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			drive_r <= `SYSRST_DRIVE_RST;
		else if (ce && done && pwrite && paddr == `SYSRST_OFS_DRIVE)
			drive_r <= pwdata[CFG_W-1:0];
	end

	// Control: trigger bits self-clear into one-cycle pulses
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hard_go_r    <= 1'b0;
			soft_go_r    <= 1'b0;
			br_go_r      <= '0;
			bist_r       <= 1'b0;
			rephase_en_r <= 1'b1;
		end
		else if (ce)
		begin
			hard_go_r <= 1'b0;
			soft_go_r <= 1'b0;
			br_go_r   <= '0;
			if (done && pwrite && paddr == `SYSRST_OFS_CONTROL)
			begin
				hard_go_r    <= pwdata[`SYSRST_CTL_HARD];
				soft_go_r    <= pwdata[`SYSRST_CTL_SOFT];
				br_go_r      <= pwdata[`SYSRST_CTL_BRIDGE_LO +: NB_BRIDGES];
				bist_r       <= pwdata[`SYSRST_CTL_BIST];
				rephase_en_r <= pwdata[`SYSRST_CTL_REPHASE];
			end
		end
	end

	// Sticky fatal flag survives hard resets; a new event beats the clear
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			fatal_seen_r <= 1'b0;
		else if (ce)
		begin
			if (fatal_take)
				fatal_seen_r <= 1'b1;
			else if (done && pwrite && paddr == `SYSRST_OFS_STATUS
				&& pwdata[`SYSRST_STS_FATAL])
				fatal_seen_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	// Everything runs at the host clock rate; no doubled domain lives here
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r                     <= SYSRST_ST_HOLD;
			kind_r                   <= SYSRST_K_POWER;
			cnt_r                    <= HOLD_LAST;
			post_r                   <= 2'h0;
			cpu_reset_n              <= 1'b0;
			memory_subsystem_clear_n <= 1'b0;
			ratio_select_hold_n      <= 1'b0;
			cfg_oe                   <= 1'b1;
			symmetric_request0_oe    <= 1'b1;
			symmetric_request0_n     <= 1'b0;
			power_ok_buffered_out    <= 1'b0;
			boot_fetch_en            <= 1'b0;
			capture_r                <= `SYSRST_DRIVE_RST;
			cfg_out                  <= `SYSRST_DRIVE_RST;
		end
		else if (ce)
		begin
			cfg_out              <= drive_r;
			symmetric_request0_n <= !symmetric_request0_oe;
			unique case (st_r)
				SYSRST_ST_HOLD:
				begin
					power_ok_buffered_out <= (kind_r != SYSRST_K_HARD);
					if (cnt_r == 16'h0000)
					begin
						cpu_reset_n              <= 1'b1;
						memory_subsystem_clear_n <= 1'b1;
						capture_r                <= cfg_in;
						post_r                   <= 2'h0;
						st_r                     <= SYSRST_ST_DRIVE;
					end
					else
						cnt_r <= cnt_r - 16'h0001;
				end
				SYSRST_ST_DRIVE:
				begin
					post_r <= post_r + 2'h1;
					if (post_r == CFG_LAST)
						cfg_oe <= 1'b0;
					if (post_r == REQ0_LAST)
						symmetric_request0_oe <= 1'b0;
					if (post_r == RATIO_LAST)
					begin
						ratio_select_hold_n <= 1'b1;
						st_r                <= SYSRST_ST_RUN;
						boot_fetch_en       <= 1'b1;
					end
				end
				SYSRST_ST_RUN:
				begin
					power_ok_buffered_out <= 1'b1;
					if (hard_take || fatal_take)
					begin
						st_r                  <= SYSRST_ST_HOLD;
						kind_r                <= hard_take ? SYSRST_K_HARD : SYSRST_K_FATAL;
						cnt_r                 <= HOLD_LAST;
						cpu_reset_n           <= 1'b0;
						ratio_select_hold_n   <= 1'b0;
						cfg_oe                <= 1'b1;
						symmetric_request0_oe <= 1'b1;
						boot_fetch_en         <= 1'b0;
						power_ok_buffered_out <= !hard_take;
						// Bus fatal leaves the memory subsystem running
						memory_subsystem_clear_n <= !hard_take;
					end
				end
				default:
					st_r <= SYSRST_ST_HOLD;
			endcase
		end
	end

	// Refresh burst after memory clear release; skipped after a bus fatal reset
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			refresh_left_r <= 8'h00;
			refresh_strobe <= 1'b0;
			refresh_bank   <= 2'h0;
		end
		else if (ce)
		begin
			refresh_strobe <= 1'b0;
			if (full_hold && cnt_r == 16'h0000)
				refresh_left_r <= REFRESH_ALL;
			else if (refresh_left_r != 8'h00)
			begin
				refresh_left_r <= refresh_left_r - 8'h01;
				refresh_strobe <= 1'b1;
				refresh_bank   <= refresh_left_r[1:0];
			end
		end
	end

	// Processor init: soft reset, or self-test request with a hard reset
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			init_cnt_r <= 16'h0000;
			cpu_init_n <= 1'b1;
		end
		else if (ce)
		begin
			if (soft_go_r || (hard_take && bist_r))
			begin
				init_cnt_r <= INIT_LAST;
				cpu_init_n <= 1'b0;
			end
			else if (init_cnt_r != 16'h0000)
				init_cnt_r <= init_cnt_r - 16'h0001;
			else
				cpu_init_n <= 1'b1;
		end
	end

	// ----------------------------------------
	// Per-bridge reset and PCI clock
	// ----------------------------------------
	generate
		for (genvar i = 0; i < NB_BRIDGES; i++)
		begin : g_bridge
			logic [15:0] br_cnt_r;
			logic [1:0]  div_r;
			logic [1:0]  div_nxt;
			logic        fb_d_r;
			logic        rephase;

			// A hard, fatal or soft reset, or this bridge's own reset, re-phases the clock unless software defeats it
			assign rephase = rephase_en_r
				&& (hard_take || fatal_take || soft_go_r || br_go_r[i]);
			assign div_nxt = (rephase || (pci_fb[i] && !fb_d_r)) ? 2'h1
				: (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;

			// Local bridge reset never touches the processors
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					br_cnt_r          <= 16'h0000;
					bridge_reset_n[i] <= 1'b0;
				end
				else if (ce)
				begin
					if (br_go_r[i])
						br_cnt_r <= BRIDGE_LAST;
					else if (br_cnt_r != 16'h0000)
						br_cnt_r <= br_cnt_r - 16'h0001;
					bridge_reset_n[i] <= !(full_hold || br_go_r[i]
						|| br_cnt_r != 16'h0000);
				end
			end

			// Divide by three; the feedback edge pulls the phase into line
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					div_r          <= 2'h0;
					fb_d_r         <= 1'b0;
					pci_clock_r[i] <= 1'b0;
				end
				else if (ce)
				begin
					div_r          <= div_nxt;
					fb_d_r         <= pci_fb[i];
					pci_clock_r[i] <= (div_nxt == 2'h0);
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk iff ce);
	endclocking
	default disable iff (!reset_n);

	// Queue depth one relies on a throttled third party; nothing checks it here
	a_cfg_hold_after: assert property ($rose(cpu_reset_n) |-> cfg_oe ##1 !cfg_oe)
		else $error("config lines not held exactly one clock after release");
	a_cfg_value: assert property (cfg_oe && $past(cfg_oe) |-> cfg_out == $past(drive_r))
		else $error("config lines do not carry the drive register");
	a_capture_edge: assert property ($rose(cpu_reset_n) |-> capture_r == $past(cfg_in))
		else $error("captured config differs from lines at release");
	a_ratio_lag: assert property ($rose(cpu_reset_n) |->
		!ratio_select_hold_n ##1 !ratio_select_hold_n ##1 ratio_select_hold_n)
		else $error("ratio hold not released two clocks after reset");
	a_req0_lag: assert property ($rose(cpu_reset_n) |->
		symmetric_request0_oe ##1 symmetric_request0_oe ##1 !symmetric_request0_oe)
		else $error("request zero not held two clocks after reset");
	a_pok_hard: assert property (kind_r == SYSRST_K_HARD && st_r != SYSRST_ST_RUN
		&& $past(st_r) != SYSRST_ST_RUN |-> !power_ok_buffered_out)
		else $error("buffered power good high during hard reset");
	a_fatal_mem: assert property (kind_r == SYSRST_K_FATAL |-> memory_subsystem_clear_n)
		else $error("memory cleared by bus fatal reset");
	a_refresh_load: assert property ($rose(memory_subsystem_clear_n)
		|-> refresh_left_r == REFRESH_ALL)
		else $error("refresh burst not loaded on memory release");
	a_bridge_full: assert property (full_hold |=> bridge_reset_n == '0)
		else $error("bridge out of reset during full reset");
	a_pci_div: assert property ($rose(pci_clock_r[0]) |=> !pci_clock_r[0])
		else $error("PCI clock high for more than one host clock");
	a_soft_only: assert property (soft_go_r && st_r == SYSRST_ST_RUN && !hard_take
		&& !fatal_take |=> !cpu_init_n && cpu_reset_n && memory_subsystem_clear_n)
		else $error("soft reset disturbed more than the processors");
	a_drive_keep: assert property (hard_take && !(done && pwrite
		&& paddr == `SYSRST_OFS_DRIVE) |=> $stable(drive_r))
		else $error("hard reset altered drive register");

	c_power_up: cover property ($rose(boot_fetch_en) && kind_r == SYSRST_K_POWER);
	c_hard: cover property ($rose(cpu_reset_n) && kind_r == SYSRST_K_HARD);
	c_fatal: cover property (fatal_take);
	c_bridge: cover property ($fell(bridge_reset_n[0]) && cpu_reset_n);

endmodule

// ===== dv/sysrst_bus_agent.sv
// Far-side bus agent: boot configuration lines and PCI clock feedback buffers.
// Assumes the sequencer's clock and its own drive enable for the config lines.
`timescale 1ns/1ps

module sysrst_bus_agent
#(
	parameter int CFG_W = 13
)
(
	input  wire logic             clk,
	input  wire logic [CFG_W-1:0] cfg_out,
	input  wire logic             cfg_oe,
	input  wire logic [CFG_W-1:0] ovr_val,
	input  wire logic             pci_clock_a,
	input  wire logic             pci_clock_b,
	output logic      [CFG_W-1:0] cfg_in,
	output wire logic             pci_fb_a,
	output wire logic             pci_fb_b
);
	logic [CFG_W-1:0] last_r;

	// Last resolved value, so a released bus never seems to hold its data
	always_ff @(posedge clk)
	begin
		if (cfg_oe)
			last_r <= cfg_in;
	end

	// Wired-or override by another agent; a floating bus shows the inverse
	always_comb
	begin
		if (cfg_oe)
			cfg_in = cfg_out | ovr_val;
		else
			cfg_in = ~last_r;
	end

	// External clock buffer copies; small skew keeps them off the sampling edge
	assign #2 pci_fb_a = pci_clock_a;
	assign #2 pci_fb_b = pci_clock_b;
endmodule

// ===== dv/tb_sysrst_seq.sv
// Self-checking bench for the reset sequencer, driven over APB.
// Assumes the sequencer package, map header and the bus agent model.
`timescale 1ns/1ps
`include "sysrst_map.svh"

module tb_sysrst_seq;
	import sysrst_pkg::*;

	localparam int HOLD = 3;
	localparam int INIT = 3;
	localparam int BRG  = 3;

	logic        clk = 1'b0;
	logic        reset_n, psel, penable, pwrite, bus_fatal_n;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, cfg_oe, req0_n, req0_oe, cpu_reset_n, cpu_init_n;
	logic        ratio_n, mem_clr_n, refresh_strobe, pok, boot_fetch_en;
	logic [1:0]  refresh_bank, bridge_reset_n;
	logic [12:0] cfg_in, cfg_out, ovr, drv_exp;
	wire         pci_a, pci_b, fb_a, fb_b;
	int          err_total = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          nref, k = 9;
	int          nbank [4];
	int          init_lo, rst_lo, mem_lo, br0_lo, br1_lo, pa_hi, pb_hi;
	logic        rst_prev = 1'b0;
	logic [31:0] rd;
	logic        er;

	always #20 clk = ~clk;

	sysrst_seq #(.HOLD_CYC(HOLD), .INIT_CYC(INIT), .BRIDGE_CYC(BRG)) uut (
		.clk(clk), .reset_n(reset_n), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfg_in(cfg_in), .cfg_out(cfg_out),
		.cfg_oe(cfg_oe), .bus_fatal_n(bus_fatal_n), .symmetric_request0_n(req0_n),
		.symmetric_request0_oe(req0_oe), .cpu_reset_n(cpu_reset_n),
		.cpu_init_n(cpu_init_n), .ratio_select_hold_n(ratio_n),
		.memory_subsystem_clear_n(mem_clr_n), .refresh_strobe(refresh_strobe),
		.refresh_bank(refresh_bank), .power_ok_buffered_out(pok),
		.boot_fetch_en(boot_fetch_en), .bridge_reset_n(bridge_reset_n),
		.pci_fb_a(fb_a), .pci_fb_b(fb_b), .pci_clock_a(pci_a), .pci_clock_b(pci_b));

	sysrst_bus_agent agent (
		.clk(clk), .cfg_out(cfg_out), .cfg_oe(cfg_oe), .ovr_val(ovr),
		.pci_clock_a(pci_a), .pci_clock_b(pci_b), .cfg_in(cfg_in),
		.pci_fb_a(fb_a), .pci_fb_b(fb_b));

	// ----------------------------------------
	// Checking and verdict
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard: the whole run needs well under two thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			give_verdict;
		end
	end

	// ----------------------------------------
	// Bus and wait tasks
	// ----------------------------------------
	// Request held until pready is seen at an edge; data taken at that edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Only the hang guard ends this wait
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Boot fetch enable marks the end of a sequence; refresh then runs out
	task automatic wait_boot;
		int n;
		repeat (3) @(posedge clk);
		for (n = 0; n < 200 && boot_fetch_en !== 1'b1; n++)
			@(posedge clk);
		chk(boot_fetch_en, 32'h1);
		repeat (40) @(posedge clk);
	endtask

	// Low and high times of the reset and clock outputs over a window
	task automatic watch(input int ncyc);
		{init_lo, rst_lo, mem_lo, br0_lo, br1_lo, pa_hi, pb_hi} = '0;
		repeat (ncyc)
		begin
			@(posedge clk);
			init_lo += (cpu_init_n === 1'b0);
			rst_lo += (cpu_reset_n === 1'b0);
			mem_lo += (mem_clr_n === 1'b0);
			br0_lo += (bridge_reset_n[0] === 1'b0);
			br1_lo += (bridge_reset_n[1] === 1'b0);
			pa_hi += (pci_a === 1'b1);
			pb_hi += (pci_b === 1'b1);
		end
	endtask

	// Refresh pulses counted between resets
	always @(posedge clk)
	begin
		if (refresh_strobe === 1'b1)
		begin
			nref++;
			nbank[refresh_bank]++;
		end
	end

	// Release sequence seen from the edges after processor reset rises
	always @(posedge clk)
	begin
		if (cpu_reset_n === 1'b1 && rst_prev === 1'b0)
			k = 0;
		else if (k < 9)
			k++;
		rst_prev = cpu_reset_n;
		if (k == 0)
		begin
			chk(cfg_oe, 32'h1);
			chk(cfg_out, drv_exp);
			chk(ratio_n, 32'h0);
		end
		if (k == 1)
		begin
			chk(ratio_n, 32'h0);
			chk({req0_oe, req0_n}, 32'h2);
		end
		if (k == 2)
			chk(ratio_n, 32'h1);
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		bus_fatal_n = 1'b1;
		ovr = 13'h0000;
		drv_exp = 13'h0040;
		repeat (3) @(posedge clk);
		chk(cpu_reset_n, 32'h0);
		chk(bridge_reset_n, 32'h0);
		chk({pok, mem_clr_n}, 32'h0);
		reset_n <= 1'b1;
		nref = 0;
		wait_boot;
		chk(pok, 32'h1);
		chk(nref, 32'd32);
		foreach (nbank[b]) chk(nbank[b], 32'd8);
		rchk(`SYSRST_OFS_DRIVE, 32'h40);
		rchk(`SYSRST_OFS_CAPTURE, 32'h40);
		rchk(8'h10, 32'h0);
		chk(er, 32'h1);
		// New configuration, another agent forcing one line, then hard reset
		drv_exp = 13'h0749;
		ovr <= 13'h0002;
		apb(1'b1, `SYSRST_OFS_DRIVE, 32'h749);
		nref = 0;
		apb(1'b1, `SYSRST_OFS_CONTROL, 32'h21);
		repeat (3) @(posedge clk);
		chk({pok, mem_clr_n, cpu_reset_n}, 32'h0);
		wait_boot;
		ovr <= 13'h0000;
		chk(nref, 32'd32);
		rchk(`SYSRST_OFS_CAPTURE, 32'h74B);
		rchk(`SYSRST_OFS_DRIVE, 32'h749);
		// Bus fatal reset with its detection now enabled
		bus_fatal_n <= 1'b0;
		watch(4);
		bus_fatal_n <= 1'b1;
		chk(rst_lo > 0, 32'h1);
		chk(mem_lo, 32'h0);
		chk(pok, 32'h1);
		wait_boot;
		rchk(`SYSRST_OFS_DRIVE, 32'h749);
		rchk(`SYSRST_OFS_STATUS, 32'h19);
		// Hard reset with self-test requested; full reset lengths seen
		apb(1'b1, `SYSRST_OFS_CONTROL, 32'h23);
		watch(30);
		chk(init_lo, INIT);
		chk(rst_lo, HOLD);
		chk(mem_lo, HOLD);
		chk(br0_lo, HOLD);
		wait_boot;
		rchk(`SYSRST_OFS_STATUS, 32'h19);
		apb(1'b1, `SYSRST_OFS_STATUS, 32'h1);
		rchk(`SYSRST_OFS_STATUS, 32'h18);
		// Soft reset reaches the processors only
		apb(1'b1, `SYSRST_OFS_CONTROL, 32'h24);
		watch(30);
		chk(init_lo, INIT);
		chk(rst_lo | mem_lo | br0_lo | br1_lo, 32'h0);
		// One bridge reset alone
		apb(1'b1, `SYSRST_OFS_CONTROL, 32'h28);
		watch(30);
		chk(br0_lo, BRG);
		chk(rst_lo | br1_lo | init_lo, 32'h0);
		// Quiet window: both PCI clocks high one cycle in three
		watch(30);
		chk(pa_hi, 32'd10);
		chk(pb_hi, 32'd10);
		give_verdict;
	end
endmodule
